// file: core/vip_pkg.sv
// Constants, types and reset values of the vectored interrupt priority unit.
// Assumes one CPU clock, synchronous reset and AHB-Lite register access.
// Functional notes
// [R1] Maskable requests serviced only with mask clear
// [R2] Mask flag set out of reset
// [R3] Entry starts only after current instruction ends
// [R4] Entry stacks PC, index, accumulator, condition codes
// [R5] Entry sets the global mask flag
// [R6] PC loaded from source vector after stacking
// [R7] Return restores stack and clears mask flag
// [R8] Fixed priority, source 0 highest, 13 lowest
// [R9] Any source wakes WAIT; selected ones wake HALT
// [R10] Trap ignores mask; trap and reset vectors
// [R11] External lines vector when event and unmasked
// [R12] Edge latch cleared on entering its routine
// [R13] Low configured pin blocks combined line request
// [R14] Peripheral request needs enable and clear mask
// [R15] Write zero or flag clear drops pending latch
// [R16] Auto-wakeup vector, wakes auto-wakeup halt only
// [R17] Timer overflow and time base wake active-halt
// [R18] Serial peripheral interrupt vector, wakes HALT
// [R19] Second timer overflow lowest vector, no HALT wake
// [R20] Supply-low request on flag rise, cleared on entry
// [R21] Supply-low wakes WAIT but never HALT
// [R22] Vector holds high then low address byte
package vip_pkg;
  localparam int NSRC = 14;
  localparam int CC_MASK_BIT = 3;
  // Entry and return sequence states, Gray steps along the entry path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PUSH = 3'h1, ST_VHI = 3'h3, ST_VLO = 3'h2, ST_JUMP = 3'h6, ST_POP = 3'h4
  } vip_state_e;
  // Core power mode as reported by the CPU
  typedef enum logic [2:0] {
    MD_RUN = 3'h0, MD_WAIT = 3'h1, MD_HALT = 3'h2, MD_AHALT = 3'h3, MD_AWUHALT = 3'h4
  } vip_mode_e;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PEND = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_EN = 8'h0c;
  localparam logic [7:0] OFF_SENSE = 8'h10;
  localparam logic [7:0] OFF_PSEL = 8'h14;
  localparam logic [7:0] OFF_SIS = 8'h18;
  // Vectors
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP = 16'hfffc;
  localparam logic [15:0] VEC_FIRST = 16'hfffa;
  // Source groups and wake sets
  localparam logic [13:0] PER_SRC = 14'h3f61;
  localparam logic [13:0] WAKE_HALT = 14'h101e;
  localparam logic [13:0] WAKE_AHALT = 14'h1a1e;
  localparam logic [13:0] WAKE_AWU = 14'h101f;
  // Stack byte order and sequence length
  localparam logic [2:0] STK_PCL = 3'h0;
  localparam logic [2:0] STK_PCH = 3'h1;
  localparam logic [2:0] STK_X = 3'h2;
  localparam logic [2:0] STK_A = 3'h3;
  localparam logic [2:0] PUSH_LAST = 3'h4;
  // Reset values
  localparam logic MASK_RST = 1'b1;
  localparam logic [13:0] EN_RST = 14'h0000;
  localparam logic [7:0] SENSE_RST = 8'h00;
  localparam logic [11:0] PSEL_RST = 12'h000;
  localparam logic SIS_EN_RST = 1'b0;
endpackage

// file: core/vip_core.sv
// Vectored interrupt priority unit: latches, priority, wake and entry/return sequencing.
// Assumes CPU core and peripheral flags on ref_clk; external pins and supply comparator asynchronous.
`timescale 1ns/10ps
`default_nettype none
module vip_core
  import vip_pkg::*;
(
  input wire logic ref_clk, // CPU clock, 20 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic hreadyout, // AHB slave ready
  output logic [31:0] hrdata, // AHB read data
  output logic hresp, // AHB response, always OKAY
  input wire logic instr_done, // Current instruction completes
  input wire logic trap_req, // Trap instruction executed
  input wire logic ret_req, // Return instruction executed
  input wire logic [2:0] cpu_mode, // Power mode, vip_mode_e
  input wire logic [15:0] cpu_pc, // Program counter to stack
  input wire logic [7:0] cpu_x, // Index register to stack
  input wire logic [7:0] cpu_a, // Accumulator to stack
  input wire logic [7:0] cpu_cc, // Condition code register
  input wire logic [7:0] vec_data, // Vector byte, cycle after read
  input wire logic auto_wakeup_source, // Auto-wakeup flag level
  input wire logic [7:0] periph_flag, // Flags of sources 5,6,8..13
  input wire logic [11:0] ext_pins, // Three pins per external line
  input wire logic supply_low_flag, // Supply comparator, async
  output logic stk_push, // Push strobe
  output logic stk_pop, // Pop strobe
  output logic [2:0] stk_sel, // Stacked register select
  output logic [7:0] stk_data, // Byte to push
  output logic vec_rd, // Vector byte read
  output logic [15:0] vec_addr, // Vector byte address
  output logic pc_load, // Load program counter
  output logic [15:0] pc_value, // New program counter
  output logic mask_flag, // Global mask flag
  output logic wake // Wake the core
);

  // ==========================================================
  // Functions
  // Lowest-numbered request wins
  function automatic logic [4:0] prio_pick(input logic [13:0] r);
    logic [4:0] p;
    p = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (r[i]) p = {1'b1, 4'(i)};
    end
    return p;
  endfunction

  // Sensitivity: 01 rising, 10 falling, 11 both, 00 low level
  function automatic logic edge_hit(input logic [1:0] m, input logic r, input logic f);
    return (m[0] & r) | (m[1] & f);
  endfunction

  // Byte pushed at each stacking step
  function automatic logic [7:0] stk_byte(input logic [2:0] s, input logic [15:0] pc,
                                          input logic [7:0] x, input logic [7:0] a, input logic [7:0] cc);
    logic [7:0] b;
    b = cc;
    if (s == STK_PCL) b = pc[7:0];
    else if (s == STK_PCH) b = pc[15:8];
    else if (s == STK_X) b = x;
    else if (s == STK_A) b = a;
    return b;
  endfunction

  // ==========================================================
  // Declarations
  logic [11:0] pin_s1_r, pin_s2_r;
  logic sup_s1_r, sup_s2_r, sup_prev_r, sup_lat_r;
  logic [3:0] line_prev_r, ext_lat_r;
  logic [13:0] flag_prev_r, per_lat_r, irq_en_r;
  logic [7:0] sense_r;
  logic [11:0] psel_r;
  logic sis_en_r;
  logic wr_r, rd_r;
  logic [7:0] addr_q;
  vip_state_e state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [3:0] src_r;
  logic trap_r, trap_pend_r, ret_pend_r;
  logic [15:0] vec_r;
  logic [7:0] hi_r, cc_q_r;
  logic [3:0] line_lvl, line_on, ext_req, ext_set;
  logic [13:0] src_flag, req, per_clr, ent_hot, wake_set;
  logic [4:0] best;
  logic trap_any, take_ent, take_ret, pop_done, mask_nxt, wake_nxt;
  logic [7:0] cc_cur;
  logic [31:0] rd_mux;
  logic acc, w_ctrl, w_pend, w_en, w_sense, w_psel, w_sis;

  // ==========================================================
  // Input synchronisers for asynchronous pins
  always_ff @(posedge ref_clk) begin
    pin_s1_r <= ext_pins;
    pin_s2_r <= pin_s1_r;
    sup_s1_r <= supply_low_flag;
    sup_s2_r <= sup_s1_r;
  end

  // ==========================================================
  // External lines: combine pins, detect events
  for (genvar i = 0; i < 4; i++) begin : g_line
    // All configured pins high; any low one blocks the line
    assign line_lvl[i] = &(pin_s2_r[3*i +: 3] | ~psel_r[3*i +: 3]); // R13
    assign line_on[i] = |psel_r[3*i +: 3];
    assign ext_set[i] = line_on[i] & edge_hit(sense_r[2*i +: 2], line_lvl[i] & ~line_prev_r[i],
                                              ~line_lvl[i] & line_prev_r[i]);
    // Level mode asks while low, edge modes ask from the latch
    assign ext_req[i] = line_on[i] & ((sense_r[2*i +: 2] == 2'b00) ? ~line_lvl[i] : ext_lat_r[i]); // R11
  end

  // ==========================================================
  // Request vector and selection
  assign src_flag = {periph_flag[7:2], 1'b0, periph_flag[1:0], 4'h0, auto_wakeup_source};
  assign req = (per_lat_r & irq_en_r & PER_SRC) | {6'h00, sup_lat_r, 2'b00, ext_req, 1'b0}; // R14
  assign best = prio_pick(req); // R8
  assign trap_any = trap_pend_r | trap_req;
  // Entry only at instruction end; trap regardless of mask
  assign take_ent = (state_r == ST_IDLE) & instr_done & ~take_ret
                    & (trap_any | (best[4] & ~mask_flag)); // R1 R3 R10
  assign take_ret = (state_r == ST_IDLE) & (ret_pend_r | ret_req);
  assign pop_done = (state_r == ST_POP) & (cnt_r == PUSH_LAST);
  assign ent_hot = (take_ent & ~trap_any) ? (14'h0001 << best[3:0]) : 14'h0000;
  // Peripheral latch drops when its flag falls or software writes zero
  assign per_clr = (~src_flag & flag_prev_r) | (w_pend ? ~hwdata[13:0] : 14'h0000); // R15

  // Wake sets per mode; supply source excluded from halt sets
  assign wake_set = (cpu_mode == MD_WAIT) ? 14'h3fff :
                    (cpu_mode == MD_HALT) ? WAKE_HALT :
                    (cpu_mode == MD_AHALT) ? WAKE_AHALT :
                    (cpu_mode == MD_AWUHALT) ? WAKE_AWU : 14'h0000; // R9 R16 R17 R18 R19 R21
  assign wake_nxt = |(req & wake_set);

  // Condition codes as they stand before entry
  always_comb begin
    cc_cur = cpu_cc;
    cc_cur[CC_MASK_BIT] = mask_flag;
  end

  // ==========================================================
  // Latches of pending requests, set wins over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      line_prev_r <= 4'hf;
      ext_lat_r <= 4'h0;
      flag_prev_r <= 14'h0000;
      per_lat_r <= 14'h0000;
      sup_prev_r <= 1'b0;
      sup_lat_r <= 1'b0;
    end else begin
      line_prev_r <= line_lvl;
      ext_lat_r <= ext_set | (ext_lat_r & ~ent_hot[4:1]); // R12
      flag_prev_r <= src_flag;
      per_lat_r <= ((src_flag & ~flag_prev_r) | (per_lat_r & ~per_clr)) & PER_SRC; // R15
      sup_prev_r <= sup_s2_r;
      sup_lat_r <= (sup_s2_r & ~sup_prev_r & sis_en_r) | (sup_lat_r & ~ent_hot[7]); // R20
    end
  end

  // ==========================================================
  // Entry and return sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 3'h0;
        if (take_ret) state_nxt = ST_POP;
        else if (take_ent) state_nxt = ST_PUSH;
      end
      ST_PUSH, ST_POP: begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == PUSH_LAST) begin
          cnt_nxt = 3'h0;
          state_nxt = (state_r == ST_PUSH) ? ST_VHI : ST_IDLE;
        end
      end
      ST_VHI: state_nxt = ST_VLO;
      ST_VLO: state_nxt = ST_JUMP;
      ST_JUMP: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Mask: hardware set on entry, cleared at end of return, else software
  assign mask_nxt = take_ent ? 1'b1 : pop_done ? 1'b0 : w_ctrl ? hwdata[0] : mask_flag; // R5 R7

  // Sequencer state and captured entry context
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 3'h0;
      src_r <= 4'h0;
      trap_r <= 1'b0;
      vec_r <= VEC_FIRST;
      cc_q_r <= 8'h00;
      hi_r <= 8'h00;
      trap_pend_r <= 1'b0;
      ret_pend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      trap_pend_r <= (trap_pend_r | trap_req) & ~(take_ent & trap_any);
      ret_pend_r <= (ret_pend_r | ret_req) & ~take_ret;
      if (take_ent) begin
        src_r <= best[3:0];
        trap_r <= trap_any;
        vec_r <= trap_any ? VEC_TRAP : VEC_FIRST - {11'h000, best[3:0], 1'b0}; // R10 R11 R16 R17 R18 R19
        cc_q_r <= cc_cur;
      end
      if (state_r == ST_VLO) hi_r <= vec_data; // R22
    end
  end

  // Registered outputs toward the core
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_flag <= MASK_RST; // R2
      stk_push <= 1'b0;
      stk_pop <= 1'b0;
      stk_sel <= 3'h0;
      stk_data <= 8'h00;
      vec_rd <= 1'b0;
      vec_addr <= 16'h0000;
      pc_load <= 1'b0;
      pc_value <= 16'h0000;
      wake <= 1'b0;
    end else begin
      mask_flag <= mask_nxt;
      stk_push <= (state_nxt == ST_PUSH); // R4
      stk_pop <= (state_nxt == ST_POP); // R7
      stk_sel <= cnt_nxt;
      stk_data <= stk_byte(cnt_nxt, cpu_pc, cpu_x, cpu_a, cc_q_r); // R4
      vec_rd <= (state_nxt == ST_VHI) | (state_nxt == ST_VLO); // R6
      vec_addr <= (state_nxt == ST_VLO) ? vec_r + 16'h0001 : vec_r; // R22
      pc_load <= (state_r == ST_JUMP); // R6
      pc_value <= {hi_r, vec_data}; // R22
      wake <= wake_nxt;
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero-wait writes, one wait state on reads
  assign acc = hsel & htrans[1] & hready;
  assign w_ctrl = wr_r & (addr_q == OFF_CTRL);
  assign w_pend = wr_r & (addr_q == OFF_PEND);
  assign w_en = wr_r & (addr_q == OFF_EN);
  assign w_sense = wr_r & (addr_q == OFF_SENSE) & mask_flag;
  assign w_psel = wr_r & (addr_q == OFF_PSEL);
  assign w_sis = wr_r & (addr_q == OFF_SIS);

  // Read data select; unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == OFF_CTRL) rd_mux = {31'h0000_0000, mask_flag};
    else if (addr_q == OFF_PEND) rd_mux = {18'h00000, per_lat_r | {6'h00, sup_lat_r, 2'b00, ext_lat_r, 1'b0}};
    else if (addr_q == OFF_STAT) rd_mux = {10'h000, state_r != ST_IDLE, trap_r, src_r, 2'b00, req};
    else if (addr_q == OFF_EN) rd_mux = {18'h00000, irq_en_r};
    else if (addr_q == OFF_SENSE) rd_mux = {24'h000000, sense_r};
    else if (addr_q == OFF_PSEL) rd_mux = {20'h00000, psel_r};
    else if (addr_q == OFF_SIS) rd_mux = {30'h0000_0000, sup_s2_r, sis_en_r};
  end

  // Bus phase tracking and read data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      wr_r <= acc & hwrite;
      rd_r <= acc & ~hwrite;
      if (acc) addr_q <= {haddr[7:2], 2'b00};
      hreadyout <= ~(acc & ~hwrite);
      if (rd_r) hrdata <= rd_mux;
      hresp <= 1'b0;
    end
  end

  // Software registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_en_r <= EN_RST;
      sense_r <= SENSE_RST;
      psel_r <= PSEL_RST;
      sis_en_r <= SIS_EN_RST;
    end else begin
      if (w_en) irq_en_r <= hwdata[13:0];
      if (w_sense) sense_r <= hwdata[7:0];
      if (w_psel) psel_r <= hwdata[11:0];
      if (w_sis) sis_en_r <= hwdata[0];
    end
  end

endmodule
`default_nettype wire

// file: testbench/vip_core_asserts.sv
// Concurrent checks on entry, vector fetch and return sequencing of the unit.
// Assumes binding onto vip_core; one clock domain with synchronous reset.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Sequencing checker
module vip_core_asserts (
  input wire logic ref_clk, // CPU clock
  input wire logic reset, // Sync reset
  input wire logic instr_done, // Instruction end
  input wire logic [7:0] vec_data, // Vector byte
  input wire logic stk_push, // Push strobe
  input wire logic stk_pop, // Pop strobe
  input wire logic [2:0] stk_sel, // Stack select
  input wire logic vec_rd, // Vector read
  input wire logic [15:0] vec_addr, // Vector address
  input wire logic pc_load, // PC load
  input wire logic [15:0] pc_value, // New PC
  input wire logic mask_flag // Mask flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Entry, vector and return properties
  AST_MASK_RST: assert property ($fell(reset) |-> mask_flag)
    else $error("mask clear after reset");
  AST_ENTRY_DONE: assert property ($rose(stk_push) |-> $past(instr_done))
    else $error("entry not at instruction end");
  AST_PUSH_RUN: assert property ($rose(stk_push) |-> stk_push [*5] ##1 !stk_push)
    else $error("push run not five bytes");
  AST_PUSH_ORDER: assert property ($rose(stk_push) |-> stk_sel == 3'h0 ##1 stk_sel == 3'h1 ##1 stk_sel == 3'h2
    ##1 stk_sel == 3'h3 ##1 stk_sel == 3'h4) else $error("push order wrong");
  AST_MASK_ENTRY: assert property ($rose(stk_push) |-> mask_flag [*5])
    else $error("mask not set during entry");
  AST_VEC_AFTER: assert property ($fell(stk_push) |-> vec_rd ##1 vec_rd ##1 !vec_rd)
    else $error("vector read not after stacking");
  AST_VEC_PAIR: assert property ($rose(vec_rd) |=> vec_addr == $past(vec_addr) + 16'h1)
    else $error("vector low byte address wrong");
  AST_PC_LOAD: assert property ($rose(vec_rd) |-> ##3 pc_load ##1 !pc_load)
    else $error("pc load not after vector read");
  AST_PC_VALUE: assert property (pc_load |-> pc_value == {$past(vec_data, 2), $past(vec_data)})
    else $error("pc value not vector bytes");
  AST_POP_RUN: assert property ($rose(stk_pop) |-> stk_pop [*5] ##1 !stk_pop)
    else $error("pop run not five bytes");
  AST_RET_UNMASK: assert property ($fell(stk_pop) |-> !mask_flag)
    else $error("mask not cleared by return");
endmodule
bind vip_core vip_core_asserts u_chk (.ref_clk(ref_clk), .reset(reset), .instr_done(instr_done),
  .vec_data(vec_data), .stk_push(stk_push), .stk_pop(stk_pop), .stk_sel(stk_sel), .vec_rd(vec_rd),
  .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value), .mask_flag(mask_flag));
`default_nettype wire

// file: testbench/vip_cpu_model.sv
// CPU side model: vector memory and stack store for the unit's core interface.
// Assumes vector bytes are read one cycle after the address is shown.
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Vector memory and stack
module vip_cpu_model (
  input wire logic ref_clk, // CPU clock
  input wire logic reset, // Sync reset
  input wire logic vec_rd, // Vector read
  input wire logic [15:0] vec_addr, // Vector address
  input wire logic stk_push, // Push strobe
  input wire logic [2:0] stk_sel, // Stack select
  input wire logic [7:0] stk_data, // Pushed byte
  output logic [7:0] vec_data // Vector byte
);
  logic [7:0] stk [0:4];
  // Handler high byte at even address, low byte at odd
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vec_data <= 8'h00;
    end else if (vec_rd) begin
      vec_data <= vec_addr[0] ? vec_addr[7:0] : 8'h9c;
    end else begin
      vec_data <= ~vec_data; // Bus released, no stale value
    end
    if (stk_push) begin
      stk[stk_sel] <= stk_data;
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_vectored_interrupt_priority_unit.sv
// Self-checking bench: register bus tasks, entry/return sequences and wake checks.
// Assumes vip_core, vip_cpu_model and the bound checker are compiled beforehand.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_vectored_interrupt_priority_unit import vip_pkg::*;;
  logic ref_clk, reset, hsel, hwrite, hready, instr_done, trap_req, ret_req, auto_wakeup_source, supply_low_flag;
  logic hreadyout, hresp, stk_push, stk_pop, vec_rd, pc_load, mask_flag, wake;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize, cpu_mode, stk_sel;
  logic [15:0] cpu_pc, vec_addr, pc_value, pc_seen;
  logic [11:0] ext_pins;
  logic [7:0] cpu_x, cpu_a, cpu_cc, vec_data, periph_flag, stk_data;
  int n_errors = 0, samples_checked = 0, n_load = 0;
  assign hready = hreadyout;
  // ============================================================
  // Instances
  vip_core dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .instr_done(instr_done), .trap_req(trap_req), .ret_req(ret_req), .cpu_mode(cpu_mode), .cpu_pc(cpu_pc),
    .cpu_x(cpu_x), .cpu_a(cpu_a), .cpu_cc(cpu_cc), .vec_data(vec_data), .auto_wakeup_source(auto_wakeup_source),
    .periph_flag(periph_flag), .ext_pins(ext_pins), .supply_low_flag(supply_low_flag), .stk_push(stk_push),
    .stk_pop(stk_pop), .stk_sel(stk_sel), .stk_data(stk_data), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .pc_load(pc_load), .pc_value(pc_value), .mask_flag(mask_flag), .wake(wake));
  vip_cpu_model cpu_u (.ref_clk(ref_clk), .reset(reset), .vec_rd(vec_rd), .vec_addr(vec_addr),
    .stk_push(stk_push), .stk_sel(stk_sel), .stk_data(stk_data), .vec_data(vec_data));
  // Clock and program counter load tally
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (pc_load === 1'b1) begin
    n_load <= n_load + 1;
    pc_seen <= pc_value;
  end
  // ============================================================
  // Tasks
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task pulse_done;
    @(posedge ref_clk) instr_done <= 1'b1;
    @(posedge ref_clk) instr_done <= 1'b0;
  endtask
  task automatic entry(input logic [15:0] v, input logic m);
    int i, n;
    logic [7:0] cc;
    cc = cpu_cc;
    cc[CC_MASK_BIT] = m;
    n = n_load;
    pulse_done();
    for (i = 0; i < 40 && n_load == n; i++) @(negedge ref_clk);
    `CHK(n_load, n + 1)
    `CHK(pc_seen, {8'h9c, v[7:0] | 8'h01})
    `CHK({cpu_u.stk[4], cpu_u.stk[3], cpu_u.stk[2], cpu_u.stk[1], cpu_u.stk[0]}, {cc, cpu_a, cpu_x, cpu_pc})
    `CHK(mask_flag, 1'b1)
  endtask
  task automatic no_entry;
    int n;
    n = n_load;
    pulse_done();
    repeat (12) @(negedge ref_clk);
    `CHK(n_load, n)
  endtask
  task leave;
    @(posedge ref_clk) ret_req <= 1'b1;
    @(posedge ref_clk) ret_req <= 1'b0;
    repeat (8) @(negedge ref_clk);
    `CHK(mask_flag, 1'b0)
  endtask
  task automatic wk(input logic [2:0] m, input logic e);
    @(posedge ref_clk) cpu_mode <= m;
    repeat (6) @(negedge ref_clk);
    `CHK(wake, e)
  endtask
  task test_done;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ============================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("Error at %0t: timeout", $time);
    test_done();
  end
  // ============================================================
  // Test sequence
  initial begin
    {hsel, hwrite, instr_done, trap_req, ret_req, auto_wakeup_source, supply_low_flag} = '0;
    haddr = '0; hwdata = '0; htrans = 2'b00; hsize = 3'h2; cpu_mode = MD_RUN; periph_flag = 8'h00;
    cpu_pc = 16'h1234; cpu_x = 8'h56; cpu_a = 8'h78; cpu_cc = 8'h00; reset = 1'b1;
    ext_pins = 12'hfff;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    `CHK(mask_flag, 1'b1)
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK(q[0], 1'b1)
    @(posedge ref_clk) trap_req <= 1'b1;
    @(posedge ref_clk) trap_req <= 1'b0;
    entry(VEC_TRAP, 1'b1);
    leave();
    // Masked request held, then taken once unmasked
    ahb(1'b1, OFF_CTRL, 32'h1);
    auto_wakeup_source <= 1'b1;
    ahb(1'b1, OFF_EN, 32'h3f61);
    no_entry();
    wk(MD_AWUHALT, 1'b1);
    wk(MD_HALT, 1'b0);
    cpu_mode <= MD_RUN;
    ahb(1'b1, OFF_CTRL, 32'h0);
    entry(VEC_FIRST, 1'b0);
    auto_wakeup_source <= 1'b0;
    leave();
    // Fixed priority among sources 5, 12 and 13
    periph_flag <= 8'hc1;
    entry(16'hfff0, 1'b0);
    periph_flag[0] <= 1'b0;
    leave();
    entry(16'hffe2, 1'b0);
    periph_flag[6] <= 1'b0;
    leave();
    entry(16'hffe0, 1'b0);
    periph_flag[7] <= 1'b0;
    leave();
    // Pending kept while disabled, lost on write of zero
    ahb(1'b1, OFF_EN, 32'h0);
    periph_flag[2] <= 1'b1;
    no_entry();
    ahb(1'b0, OFF_PEND, 32'h0);
    `CHK(q[8], 1'b1)
    ahb(1'b1, OFF_PEND, 32'h0);
    ahb(1'b1, OFF_EN, 32'h3f61);
    no_entry();
    periph_flag <= 8'h01;
    // Wake sets per power mode
    wk(MD_WAIT, 1'b1);
    wk(MD_HALT, 1'b0);
    periph_flag <= 8'h08;
    wk(MD_AHALT, 1'b1);
    wk(MD_HALT, 1'b0);
    periph_flag <= 8'h40;
    wk(MD_HALT, 1'b1);
    periph_flag <= 8'h00;
    ahb(1'b1, OFF_SIS, 32'h1);
    supply_low_flag <= 1'b1;
    wk(MD_WAIT, 1'b1);
    wk(MD_HALT, 1'b0);
    cpu_mode <= MD_RUN;
    entry(16'hffec, 1'b0);
    ahb(1'b0, OFF_PEND, 32'h0);
    `CHK(q[7], 1'b0)
    leave();
    // External line 0 over pins 0 and 1, rising edge
    ahb(1'b1, OFF_CTRL, 32'h1);
    ahb(1'b1, OFF_SENSE, 32'h1);
    ahb(1'b1, OFF_PSEL, 32'h3);
    ext_pins[1:0] <= 2'b00;
    repeat (4) @(posedge ref_clk);
    ext_pins[1] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, OFF_PEND, 32'h0);
    `CHK(q[1], 1'b0)
    ext_pins[0] <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ahb(1'b0, OFF_PEND, 32'h0);
    `CHK(q[1], 1'b1)
    no_entry();
    ahb(1'b1, OFF_CTRL, 32'h0);
    entry(16'hfff8, 1'b0);
    ahb(1'b0, OFF_PEND, 32'h0);
    `CHK(q[1], 1'b0)
    leave();
    test_done();
  end
endmodule
`default_nettype wire
